// >>> fmc_pkg.sv
// Purpose: Constants and carriers for the fan monitor configuration bank
// Assumes: Byte address of each register is four times its index
// Notes:   Temperatures are signed whole degrees
// Behaviour
// - Hysteresis register bits 3:0 hold processor channel hysteresis, 0 to 15 degrees.
// - Hysteresis register bits 7:4 hold remote 2 hysteresis, 0 to 15 degrees.
// - Below minimum threshold, fan stays at minimum until threshold minus hysteresis.
// - Over limit forces full duty until temperature drops below limit minus hysteresis.
// - Test enable bit 0 enters logic tree test mode; clearing leaves it.
// - While lock bit is set, writes to every register have no effect.
// - Offset registers are added to remote 1, local, remote 2 measurements.
// - Offset range bit selects range and resolution of all offsets.
// - With detect enable set, bits 3:1 reflect four-wire fan presence.
// - Bits 1, 2, 3 read 1 when four-wire fan found on fans a, b, c.
// - Bit 4 turns averaging off, converting sixteen times faster.
// - Bit 5 bypasses all four attenuators; auxiliary bits bypass them per channel.
// - Bit 6 converts only the channel chosen by the channel code.
// - Codes 0-4 voltages, 5-7 temperatures, 8 termination voltage, 9 current monitor.
// - Bit 7 enters shutdown mode.
// - Above minimum threshold, fan runs minimum and rises with temperature.
// - Over temperature limit of 0x80 disables the full duty fail-safe.
package fmc_pkg;
   localparam logic [7:0] IDX_HYST      = 8'h6E;
   localparam logic [7:0] IDX_TEST      = 8'h6F;
   localparam logic [7:0] IDX_OFF_R1    = 8'h70;
   localparam logic [7:0] IDX_OFF_LOC   = 8'h71;
   localparam logic [7:0] IDX_OFF_R2    = 8'h72;
   localparam logic [7:0] IDX_CFG2      = 8'h73;
   localparam logic [7:0] IDX_AUX       = 8'h7F;
   localparam logic [7:0] RST_HYST      = 8'h44;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [11:0] RST_AUX      = 12'h000;
   localparam int CFG2_DETECT_EN  = 0;
   localparam int CFG2_AVG_OFF    = 4;
   localparam int CFG2_ATTENUATOR_BYPASS       = 5;
   localparam int CFG2_SINGLE     = 6;
   localparam int CFG2_SHUTDOWN   = 7;
   localparam int AUX_LOCK        = 0;
   localparam int AUX_OFF_HALF    = 1;
   localparam logic [7:0] OVER_TEMP_LIMIT_OFF     = 8'h80;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;
   localparam int NUM_SINGLE_CHANNEL_CONVERT_CH = 10;

   // One temperature channel as seen from the measurement side
   typedef struct packed {
      logic [7:0] raw;
      logic [7:0] tmin;
      logic [7:0] over_temp_limit;
   } fmc_temp_in_t;

   // Fan loop decision for one channel
   typedef struct packed {
      logic       run;
      logic       full;
      logic [7:0] excess;
      logic [7:0] reading;
   } fmc_loop_out_t;
endpackage

// >>> fmc_regs.sv
// Purpose: AXI4-Lite register bank with fan loop and converter controls
// Assumes: Channel 0 remote 1, 1 local, 2 remote 2, 3 processor
// Notes:   Remote 1 and local hysteresis arrive from a neighbouring bank
//
// Our own choice: register access over AXI4-Lite.
module fmc_regs (
   // Clock, reset, enable
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   input  wire logic                            ce,
   // AXI4-Lite write address
   input  wire logic [31:0]                     s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                     s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]                     s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                          s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   // Measurement side
   input  wire fmc_pkg::fmc_temp_in_t [3:0]     chan_in,
   input  wire logic [3:0]                      remote1_hysteresis,
   input  wire logic [3:0]                      local_hysteresis,
   input  wire logic [2:0]                      four_wire_seen,
   // Fan loop results
   output fmc_pkg::fmc_loop_out_t [3:0]         loop_out,
   output logic                                 fan_full_all,
   // Device controls
   output logic                                 logic_tree_test_on,
   output logic                                 averaging_off,
   output logic [3:0]                           attenuator_bypass,
   output logic                                 single_channel_convert,
   output logic [fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH-1:0]      single_channel_convert_channel_sel,
   output logic                                 shutdown
);

   // Register state
   logic [7:0]  hyst_reg;
   logic [7:0]  test_reg;
   logic [7:0]  off_reg [3];
   logic [7:0]  cfg2_reg;
   logic [11:0] aux_reg;

   // Bus state
   logic        aw_full_reg;
   logic        w_full_reg;
   logic [7:0]  aw_idx_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;

   // Loop state
   logic [3:0]  run_reg;
   logic [3:0]  full_reg;
   logic [7:0]  reading_reg [4];
   logic [7:0]  excess_reg [4];

   // Register index from a byte address; misaligned maps nowhere
   function automatic logic [8:0] addr_idx(input logic [31:0] a);
      logic [8:0] r;
      r = 9'h100;
      if (a[1:0] == 2'b00 && a[31:10] == '0) begin
         r = {1'b0, a[9:2]};
      end
      return r;
   endfunction

   function automatic logic idx_mapped(input logic [8:0] i);
      logic m;
      m = 1'b0;
      if (i[8] == 1'b0) begin
         m = (i[7:0] >= fmc_pkg::IDX_HYST && i[7:0] <= fmc_pkg::IDX_CFG2)
             || i[7:0] == fmc_pkg::IDX_AUX;
      end
      return m;
   endfunction

   // Clamp a ten bit sum into the signed byte range
   function automatic logic [7:0] sat8(input logic signed [9:0] v);
      logic [7:0] r;
      r = v[7:0];
      if (v > 10'sd127) begin
         r = 8'h7F;
      end else if (v < -10'sd128) begin
         r = 8'h80;
      end
      return r;
   endfunction

   // Sign extension of a byte
   function automatic logic signed [9:0] sx(input logic [7:0] b);
      return signed'({{2{b[7]}}, b});
   endfunction

   // Detected fan bits, forced low when detection is off
   wire         detect_en   = cfg2_reg[fmc_pkg::CFG2_DETECT_EN];
   wire  [2:0]  detect_bits = detect_en ? four_wire_seen : 3'b000;
   wire  [7:0]  cfg2_view   = {cfg2_reg[7:4], detect_bits, cfg2_reg[0]};
   wire         locked      = aux_reg[fmc_pkg::AUX_LOCK];

   // Write path
   wire         do_write  = aw_full_reg && w_full_reg && !bvalid_reg;
   wire  [8:0]  w_idx     = {1'b0, aw_idx_reg};
   wire         w_mapped  = aw_idx_reg != 8'hFF && idx_mapped(w_idx);
   wire         w_commit  = do_write && w_mapped && !locked;
   wire  [7:0]  wbyte     = wdata_reg[7:0];
   wire         wlane0    = wstrb_reg[0];
   wire         wlane1    = wstrb_reg[1];
   wire  [8:0]  aw_idx_in = addr_idx(s_axi_awaddr);

   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready  = !w_full_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_idx_reg  <= 8'h00;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg  <= aw_idx_in[8] ? 8'hFF : aw_idx_in[7:0];
         end else if (do_write) begin
            aw_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= fmc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= w_mapped ? fmc_pkg::RESP_OKAY : fmc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Register writes; reserved test bits are stored as written
   wire hit_hyst = w_commit && wlane0 && aw_idx_reg == fmc_pkg::IDX_HYST;
   wire hit_test = w_commit && wlane0 && aw_idx_reg == fmc_pkg::IDX_TEST;
   wire hit_cfg2 = w_commit && wlane0 && aw_idx_reg == fmc_pkg::IDX_CFG2;
   wire hit_aux  = w_commit && aw_idx_reg == fmc_pkg::IDX_AUX;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hyst_reg <= fmc_pkg::RST_HYST;
         test_reg <= fmc_pkg::RST_ZERO;
         cfg2_reg <= fmc_pkg::RST_ZERO;
      end else if (ce) begin
         if (hit_hyst) begin
            hyst_reg <= wbyte;
         end
         if (hit_test) begin
            test_reg <= wbyte;
         end
         if (hit_cfg2) begin
            // Presence bits are not storage
            cfg2_reg <= {wbyte[7:4], 3'b000, wbyte[0]};
         end
      end
   end

   // Lock is sticky: once set only reset clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_reg <= fmc_pkg::RST_AUX;
      end else if (ce && hit_aux) begin
         if (wlane0) begin
            aux_reg[7:0] <= wbyte;
         end
         if (wlane1) begin
            aux_reg[11:8] <= wdata_reg[11:8];
         end
      end
   end

   for (genvar k = 0; k < 3; k++) begin : g_off
      wire hit_off = w_commit && wlane0
                     && aw_idx_reg == fmc_pkg::IDX_OFF_R1 + 8'(k);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            off_reg[k] <= fmc_pkg::RST_ZERO;
         end else if (ce && hit_off) begin
            off_reg[k] <= wbyte;
         end
      end
   end

   // Read path
   wire  [8:0]  r_idx    = addr_idx(s_axi_araddr);
   wire         r_mapped = idx_mapped(r_idx);
   logic [31:0] r_word;

   always_comb begin
      r_word = 32'h0000_0000;
      unique case (r_idx[7:0])
         fmc_pkg::IDX_HYST:    r_word[7:0]  = hyst_reg;
         fmc_pkg::IDX_TEST:    r_word[7:0]  = test_reg;
         fmc_pkg::IDX_OFF_R1:  r_word[7:0]  = off_reg[0];
         fmc_pkg::IDX_OFF_LOC: r_word[7:0]  = off_reg[1];
         fmc_pkg::IDX_OFF_R2:  r_word[7:0]  = off_reg[2];
         fmc_pkg::IDX_CFG2:    r_word[7:0]  = cfg2_view;
         fmc_pkg::IDX_AUX:     r_word[11:0] = aux_reg;
         default:              r_word       = 32'h0000_0000;
      endcase
      if (!r_mapped) begin
         r_word = 32'h0000_0000;
      end
   end

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= fmc_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (ce) begin
         if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= r_word;
            rresp_reg  <= r_mapped ? fmc_pkg::RESP_OKAY : fmc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Fan loops; processor channel carries no offset
   wire  [3:0] hyst_of [4];
   assign hyst_of[0] = remote1_hysteresis;
   assign hyst_of[1] = local_hysteresis;
   assign hyst_of[2] = hyst_reg[7:4];
   assign hyst_of[3] = hyst_reg[3:0];

   // Half-degree offset units trade range for resolution
   wire off_half = aux_reg[fmc_pkg::AUX_OFF_HALF];

   for (genvar c = 0; c < 4; c++) begin : g_loop
      wire  [7:0]        off_raw = (c < 3) ? off_reg[c % 3] : 8'h00;
      wire signed [9:0]  off_s   = off_half ? (sx(off_raw) >>> 1)
                                            : sx(off_raw);
      wire signed [9:0]  t_sum   = sx(chan_in[c].raw) + off_s;
      wire  [7:0]        t_adj   = sat8(t_sum);
      wire signed [9:0]  t       = sx(t_adj);
      wire signed [9:0]  h       = signed'({6'b000000, hyst_of[c]});
      wire signed [9:0]  tmin    = sx(chan_in[c].tmin);
      wire signed [9:0]  over_temp_limit   = sx(chan_in[c].over_temp_limit);
      wire               above   = t > tmin;
      wire               low_out = t <= tmin - h;
      wire               safe_on = chan_in[c].over_temp_limit != fmc_pkg::OVER_TEMP_LIMIT_OFF;
      wire               hot     = safe_on && t > over_temp_limit;
      wire               cool    = t < over_temp_limit - h;
      wire               run_n   = above ? 1'b1 : (low_out ? 1'b0 : run_reg[c]);
      wire               full_n  = !safe_on ? 1'b0
                                   : hot ? 1'b1
                                   : cool ? 1'b0 : full_reg[c];
      wire signed [9:0]  over    = t - tmin;
      wire  [7:0]        exc_n   = above ? over[7:0] : 8'h00;

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            run_reg[c]     <= 1'b0;
            full_reg[c]    <= 1'b0;
            reading_reg[c] <= 8'h00;
            excess_reg[c]  <= 8'h00;
         end else if (ce) begin
            run_reg[c]     <= run_n;
            full_reg[c]    <= full_n;
            reading_reg[c] <= t_adj;
            excess_reg[c]  <= exc_n;
         end
      end

      assign loop_out[c].run     = run_reg[c];
      assign loop_out[c].full    = full_reg[c];
      assign loop_out[c].excess  = excess_reg[c];
      assign loop_out[c].reading = reading_reg[c];
   end

   // Any channel over its limit drives every fan flat out
   assign fan_full_all = |full_reg;

   // Converter and device controls
   wire [3:0] single_channel_convert_code = aux_reg[11:8];

   function automatic logic [fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH-1:0] code_onehot(input logic [3:0] cd);
      logic [fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH-1:0] s;
      s = '0;
      if (cd < 4'(fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH)) begin
         s[cd] = 1'b1;
      end
      return s;
   endfunction

   assign logic_tree_test_on     = test_reg[0];
   assign averaging_off          = cfg2_reg[fmc_pkg::CFG2_AVG_OFF];
   assign attenuator_bypass      = {4{cfg2_reg[fmc_pkg::CFG2_ATTENUATOR_BYPASS]}} | aux_reg[7:4];
   assign single_channel_convert = cfg2_reg[fmc_pkg::CFG2_SINGLE];
   assign single_channel_convert_channel_sel       = single_channel_convert ? code_onehot(single_channel_convert_code)
                                   : '0;
   assign shutdown               = cfg2_reg[fmc_pkg::CFG2_SHUTDOWN];

endmodule // fmc_regs

// >>> fmc_regs_monitor.sv
// Purpose: Concurrent checks on the channel 3 fan loop, full-all output and read answers
// Assumes: Channel 3 has no offset, so its reading is the raw value
// Notes:   Hysteresis is unseen here, so run/full clearing uses 15 degrees
module fmc_regs_monitor (
   // Clock and reset
   input wire logic                             aclk,
   input wire logic                             aresetn,
   input wire logic                             ce,
   // Read bus
   input wire logic                             s_axi_arvalid,
   input wire logic                             s_axi_arready,
   input wire logic                             s_axi_rvalid,
   // Loops and controls
   input wire fmc_pkg::fmc_temp_in_t [3:0]      chan_in,
   input wire fmc_pkg::fmc_loop_out_t [3:0]     loop_out,
   input wire logic                             fan_full_all,
   input wire logic                             single_channel_convert,
   input wire logic [fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH-1:0]  single_channel_convert_channel_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic signed [8:0] t3, mn3, th3;
   logic        [7:0] ex3;
   assign t3  = $signed(chan_in[3].raw);
   assign mn3 = $signed(chan_in[3].tmin);
   assign th3 = $signed(chan_in[3].over_temp_limit);
   assign ex3 = chan_in[3].raw - chan_in[3].tmin;
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence
   sequence s_hot;
      ce && chan_in[3].over_temp_limit != fmc_pkg::OVER_TEMP_LIMIT_OFF && t3 > th3;
   endsequence
   property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_run_on; ce && t3 > mn3 |=> loop_out[3].run; endproperty
   a_run_on: assert property (p_run_on) else $error("fan not running");
   property p_run_off; ce && t3 <= mn3 - 15 |=> !loop_out[3].run; endproperty
   a_run_off: assert property (p_run_off) else $error("fan kept running");
   property p_excess; ce && t3 > mn3 |=> loop_out[3].excess == $past(ex3); endproperty
   a_excess: assert property (p_excess) else $error("excess wrong");
   property p_reading; ce |=> loop_out[3].reading == $past(chan_in[3].raw); endproperty
   a_reading: assert property (p_reading) else $error("reading wrong");
   property p_full_on; s_hot |=> loop_out[3].full; endproperty
   a_full_on: assert property (p_full_on) else $error("no full duty");
   property p_full_off; ce && t3 < th3 - 15 |=> !loop_out[3].full; endproperty
   a_full_off: assert property (p_full_off) else $error("full duty kept");
   property p_over_temp_limit_off; ce && chan_in[3].over_temp_limit == fmc_pkg::OVER_TEMP_LIMIT_OFF |=> !loop_out[3].full; endproperty
   a_over_temp_limit_off: assert property (p_over_temp_limit_off) else $error("fail-safe not off");
   property p_full_all;
      fan_full_all == (loop_out[0].full | loop_out[1].full | loop_out[2].full | loop_out[3].full);
   endproperty
   a_full_all: assert property (p_full_all) else $error("full-all mismatch");
   property p_single_channel_convert_off; !single_channel_convert |-> single_channel_convert_channel_sel == '0; endproperty
   a_single_channel_convert_off: assert property (p_single_channel_convert_off) else $error("channel chosen");
   property p_single_channel_convert_hot; $onehot0(single_channel_convert_channel_sel); endproperty
   a_single_channel_convert_hot: assert property (p_single_channel_convert_hot) else $error("several channels");
endmodule // fmc_regs_monitor
bind fmc_regs fmc_regs_monitor fmc_regs_monitor_i (.*);

// >>> fmc_host.sv
// Purpose: Host model driving the register bus
// Assumes: One write or one read at a time
// Notes:   Waits are unbounded here; the bench watchdog cuts hangs
module fmc_host (
   // Clock
   input wire logic         aclk,
   // Write channels
   output logic [31:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input wire logic         s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic         s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels
   output logic [31:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input wire logic         s_axi_arready,
   input wire logic         s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (s_axi_awready && !ad) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !dd) begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
endmodule // fmc_host

// >>> test_fan_monitor_config_registers.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Clock enable held high throughout
// Notes:   Read data checked from a queue by a watcher process
module test_fan_monitor_config_registers;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, ce = 1;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, remote1_hysteresis, local_hysteresis, attenuator_bypass;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fan_full_all;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] four_wire_seen = '0;
   fmc_pkg::fmc_temp_in_t [3:0] chan_in = '0;
   fmc_pkg::fmc_loop_out_t [3:0] loop_out;
   logic logic_tree_test_on, averaging_off, single_channel_convert, shutdown;
   logic [fmc_pkg::NUM_SINGLE_CHANNEL_CONVERT_CH-1:0] single_channel_convert_channel_sel;
   logic [33:0] exp_q[$];
   int fail_count = 0, n_compared = 0;
   logic [7:0] v, r, ix[6];
   int s;
   fmc_regs fmc_regs_i (.*);
   fmc_host fmc_host_i (.*);
   always #5 aclk = ~aclk;
   function automatic logic [31:0] ad(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task automatic bad(input string m);
      fail_count++;
      $display("Error %0t %s", $time, m);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] e);
      n_compared++;
      if (got !== e) bad("output mismatch");
   endtask
   task automatic wx(input logic [7:0] i, input logic [31:0] d, input logic [3:0] st = 4'h1);
      fmc_host_i.wr(ad(i), d, st);
   endtask
   task automatic rdx(input logic [7:0] i, input logic [7:0] e);
      exp_q.push_back({fmc_pkg::RESP_OKAY, 24'h0, e});
      fmc_host_i.rd(ad(i));
   endtask
   task automatic tloop(input int c, input int h);
      int rv[7];
      logic [1:0] ev[7];
      // Last point lies below both release thresholds for any hysteresis
      rv = '{51, 51 - h, 50 - h, 81, 81 - h, 79 - h, 20};
      ev = '{2'b10, 2'b10, 2'b00, 2'b11, 2'b11, 2'b10, 2'b00};
      chan_in[c].tmin <= 8'd50;
      chan_in[c].over_temp_limit <= 8'd80;
      foreach (rv[i]) begin
         chan_in[c].raw <= 8'(rv[i]);
         repeat (2) @(posedge aclk);
         chk({loop_out[c].run, loop_out[c].full}, ev[i]);
      end
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge aclk) begin
      if (aresetn && s_axi_rvalid && s_axi_rready) begin
         n_compared++;
         if (exp_q.size() == 0) bad("unexpected read");
         else if ({s_axi_rresp, s_axi_rdata} !== exp_q.pop_front()) bad("read data mismatch");
      end
      // Every bench write targets a mapped register, locked or not
      if (aresetn && s_axi_bvalid && s_axi_bready) begin
         n_compared++;
         if (s_axi_bresp !== fmc_pkg::RESP_OKAY) bad("write response mismatch");
      end
   end
   initial begin
      #300us;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      ix = '{fmc_pkg::IDX_HYST, fmc_pkg::IDX_TEST, fmc_pkg::IDX_OFF_R1,
             fmc_pkg::IDX_OFF_LOC, fmc_pkg::IDX_OFF_R2, fmc_pkg::IDX_CFG2};
      s = $urandom(32'hb461e574);
      remote1_hysteresis <= 4'($urandom);
      local_hysteresis <= 4'($urandom);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ix[i]) rdx(ix[i], (i == 0) ? fmc_pkg::RST_HYST : fmc_pkg::RST_ZERO);
      // Hysteresis of 4 or more keeps the fan from cycling
      wx(fmc_pkg::IDX_HYST, 32'h0000_0065);
      rdx(fmc_pkg::IDX_HYST, 8'h65);
      tloop(3, 5);
      tloop(2, 6);
      chan_in[3].raw <= 8'd90;
      chan_in[3].over_temp_limit <= fmc_pkg::OVER_TEMP_LIMIT_OFF;
      repeat (2) @(posedge aclk);
      chk({loop_out[3].full, fan_full_all}, 0);
      // Reserved test bits left at zero
      wx(fmc_pkg::IDX_TEST, 32'h0000_0001);
      chk(logic_tree_test_on, 1);
      wx(fmc_pkg::IDX_TEST, 32'h0000_0000);
      chk(logic_tree_test_on, 0);
      for (int b = 4; b < 8; b++) begin
         wx(fmc_pkg::IDX_CFG2, 32'h0000_0001 << b);
         chk({shutdown, single_channel_convert, attenuator_bypass, averaging_off},
             {b == 7, b == 6, {4{b == 5}}, b == 4});
      end
      wx(fmc_pkg::IDX_CFG2, 32'h0000_0040);
      for (int c = 0; c < 11; c++) begin
         wx(fmc_pkg::IDX_AUX, 32'(c) << 8, 4'h2);
         chk(single_channel_convert_channel_sel, (c < 10) ? 16'h0001 << c : 16'h0000);
      end
      four_wire_seen <= 3'b101;
      wx(fmc_pkg::IDX_CFG2, 32'h0000_000F);
      rdx(fmc_pkg::IDX_CFG2, 8'h0B);
      four_wire_seen <= 3'b010;
      wx(fmc_pkg::IDX_CFG2, 32'h0000_000E);
      rdx(fmc_pkg::IDX_CFG2, 8'h00);
      for (int c = 0; c < 3; c++) begin
         v = 8'($urandom);
         r = 8'($urandom);
         wx(ix[c + 2], {24'h0, v});
         rdx(ix[c + 2], v);
         chan_in[c].raw <= r;
         repeat (2) @(posedge aclk);
         s = int'($signed(v)) + int'($signed(r));
         if (s > 127) s = 127;
         if (s < -128) s = -128;
         chk(loop_out[c].reading, 8'(s));
      end
      wx(fmc_pkg::IDX_OFF_R1, 32'h0000_00FA);
      wx(fmc_pkg::IDX_AUX, 32'h0000_0002);
      chan_in[0].raw <= 8'd40;
      repeat (2) @(posedge aclk);
      chk(loop_out[0].reading, 16'd37);
      wx(fmc_pkg::IDX_AUX, 32'h0000_0050);
      chk(attenuator_bypass, 4'h5);
      exp_q.push_back({fmc_pkg::RESP_SLVERR, 32'h0000_0000});
      fmc_host_i.rd(32'h0000_0000);
      wx(fmc_pkg::IDX_AUX, 32'h0000_0001);
      wx(fmc_pkg::IDX_HYST, 32'h0000_0099);
      rdx(fmc_pkg::IDX_HYST, 8'h65);
      wx(fmc_pkg::IDX_TEST, 32'h0000_0001);
      chk(logic_tree_test_on, 0);
      repeat (4) @(posedge aclk);
      tally_and_finish();
   end
endmodule // test_fan_monitor_config_registers
